// ===== rtl/csf_pkg.sv
// Shared constants for the cyclic setpoint follower and its controller.
// Assumes one 100 MHz core clock on both ends.
package csf_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_W        = 32;
    localparam int SEL_W         = 4;
    localparam int NUM_SEL       = 15;
    localparam int STAT_W        = 16;

    typedef enum logic [SEL_W-1:0] {
        SEL_MODE    = 4'b0000,
        SEL_TGT_POS = 4'b0001,
        SEL_TGT_VEL = 4'b0010,
        SEL_SWL_MIN = 4'b0011,
        SEL_SWL_MAX = 4'b0100,
        SEL_RNG_MIN = 4'b0101,
        SEL_RNG_MAX = 4'b0110,
        SEL_FE_WIN  = 4'b0111,
        SEL_FE_TMO  = 4'b1000,
        SEL_QS_DEC  = 4'b1001,
        SEL_QS_OPT  = 4'b1010,
        SEL_MAX_SPD = 4'b1011,
        SEL_IP_PER  = 4'b1100,
        SEL_IP_IDX  = 4'b1101,
        SEL_CTRL    = 4'b1110
    } sel_e;

    localparam logic [7:0]        MODE_CSP     = 8'h08;
    localparam logic [7:0]        MODE_CSV     = 8'h09;
    localparam logic [7:0]        TIME_IDX_MS  = 8'hfd;
    localparam logic [7:0]        QS_OPT_COAST = 8'h00;
    localparam int                ST_SYNC      = 8;
    localparam int                ST_LIMIT     = 11;
    localparam int                ST_FOLLOW    = 12;
    localparam int                ST_FERR      = 13;
    localparam int                CTRL_ENABLE  = 0;
    localparam int                CTRL_QSTOP   = 1;

    localparam logic [DATA_W-1:0] RST_ZERO     = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_SWL_MIN  = 32'h8000_0000;
    localparam logic [DATA_W-1:0] RST_SWL_MAX  = 32'h7fff_ffff;
    localparam logic [DATA_W-1:0] RST_IP_PER   = 32'h0000_0001;
    localparam logic [DATA_W-1:0] RST_IP_IDX   = 32'hffff_fffd;
    localparam logic [DATA_W-1:0] RST_MAX_SPD  = 32'h0000_0100;
    localparam logic [DATA_W-1:0] ONE          = 32'h0000_0001;

    localparam int                ADDR_W       = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_POS     = 8'h44;
    localparam logic [ADDR_W-1:0] ADDR_VEL     = 8'h48;
    localparam logic [ADDR_W-1:0] ADDR_FE      = 8'h4c;
endpackage

// ===== rtl/csf_link_if.sv
// Link between the motion controller and the drive: parameter writes one way,
// status and actual values the other. Both ends share the core clock.
`timescale 1ns/1ps
interface csf_link_if;
    import csf_pkg::*;
    logic                 wr_valid;
    sel_e                 wr_sel;
    logic [DATA_W-1:0]    wr_data;
    logic [STAT_W-1:0]    status;
    logic [DATA_W-1:0]    pos_act;
    logic [DATA_W-1:0]    vel_act;
    logic [DATA_W-1:0]    fe_act;
    modport drive (input wr_valid, wr_sel, wr_data, output status, pos_act, vel_act, fe_act);
    modport ctl   (output wr_valid, wr_sel, wr_data, input status, pos_act, vel_act, fe_act);
endinterface

// ===== rtl/csf_ms_tick.sv
// Millisecond tick generator: one-cycle pulse every CYCLES enabled clocks.
// Assumes the clock enable is high for real time to pass.
`timescale 1ns/1ps
module csf_ms_tick #(
    parameter int CYCLES = 100000
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    output logic      tick
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_q;

    if (CYCLES < 1) begin : g_chk
        $error("CYCLES must be at least one");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (ce) begin
            tick  <= (cnt_q == LAST);
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule

// ===== rtl/csf_drive.sv
// Drive end: cyclic synchronous position and velocity following.
// Assumes the controller writes one target per cycle over the link.
`timescale 1ns/1ps
module csf_drive
    import csf_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input  wire logic         CORE_CLK,
    input  wire logic         RST_N,
    input  wire logic         CE,
    csf_link_if.drive         LINK,
    input  wire logic         POS_LIMIT_SW,
    input  wire logic         NEG_LIMIT_SW,
    output logic [DATA_W-1:0] MOTOR_SPEED,
    output logic [DATA_W-1:0] ACTUAL_POS
);
    typedef logic signed [DATA_W-1:0] sw_t;

    logic [DATA_W-1:0] prm_q [NUM_SEL];
    logic              tick;
    logic [DATA_W-1:0] cyc_cnt_q;
    logic              seen_q;
    logic              sync_q;
    logic [DATA_W-1:0] fe_cnt_q;
    sw_t               act_q;
    sw_t               spd_q;
    logic [STAT_W-1:0] status_q;
    logic [DATA_W-1:0] fe_out_q;

    logic              is_csp;
    logic              is_csv;
    logic              ctl_enable;
    logic              ctl_qstop;
    logic              follow;
    logic              period_ok;
    logic              cyc_end;
    logic              tgt_wr;
    sw_t               tgt_pos;
    sw_t               rng_min;
    sw_t               rng_max;
    sw_t               swl_min;
    sw_t               swl_max;
    sw_t               max_spd;
    sw_t               span;
    sw_t               wrapped;
    sw_t               demand;
    sw_t               err;
    sw_t               err_abs;
    sw_t               cmd;
    sw_t               spd_d;
    logic              lim_ex;
    logic              fe_out;

    function automatic sw_t clamp(input sw_t v, input sw_t lo, input sw_t hi);
        clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction

    csf_ms_tick #(
        .CYCLES (MS_CYCLES)
    ) u_tick (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .ce    (CE),
        .tick  (tick)
    );

    // Parameter store, written by the controller over the link
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                prm_q[i] <= RST_ZERO;
            end
            prm_q[SEL_SWL_MIN] <= RST_SWL_MIN;
            prm_q[SEL_SWL_MAX] <= RST_SWL_MAX;
            prm_q[SEL_IP_PER]  <= RST_IP_PER;
            prm_q[SEL_IP_IDX]  <= RST_IP_IDX;
            prm_q[SEL_MAX_SPD] <= RST_MAX_SPD;
        end else if (CE && LINK.wr_valid) begin
            // Targets are absolute: a repeat just stores the same value again
            prm_q[LINK.wr_sel] <= LINK.wr_data;
        end
    end

    assign is_csp     = (prm_q[SEL_MODE][7:0] == MODE_CSP);
    assign is_csv     = (prm_q[SEL_MODE][7:0] == MODE_CSV);
    assign ctl_enable = prm_q[SEL_CTRL][CTRL_ENABLE];
    assign ctl_qstop  = prm_q[SEL_CTRL][CTRL_QSTOP];
    assign tgt_pos    = sw_t'(prm_q[SEL_TGT_POS]);
    assign rng_min    = sw_t'(prm_q[SEL_RNG_MIN]);
    assign rng_max    = sw_t'(prm_q[SEL_RNG_MAX]);
    assign swl_min    = sw_t'(prm_q[SEL_SWL_MIN]);
    assign swl_max    = sw_t'(prm_q[SEL_SWL_MAX]);
    assign max_spd    = sw_t'(prm_q[SEL_MAX_SPD]);

    // Cycle length is period milliseconds; any other time index is unsupported
    assign period_ok = (prm_q[SEL_IP_IDX][7:0] == TIME_IDX_MS)
                       && (prm_q[SEL_IP_PER] != RST_ZERO);
    assign cyc_end   = tick && (cyc_cnt_q + ONE >= prm_q[SEL_IP_PER]);
    assign tgt_wr    = CE && LINK.wr_valid
                       && ((is_csp && LINK.wr_sel == SEL_TGT_POS)
                        || (is_csv && LINK.wr_sel == SEL_TGT_VEL));

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cyc_cnt_q <= RST_ZERO;
        end else if (CE && tick) begin
            cyc_cnt_q <= cyc_end ? RST_ZERO : cyc_cnt_q + ONE;
        end
    end

    // Sync holds while each cycle carries at least one target; a write in the
    // closing cycle counts for that cycle
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            seen_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (CE) begin
            if (cyc_end) begin
                seen_q <= 1'b0;
                sync_q <= period_ok && (seen_q || tgt_wr);
            end else begin
                seen_q <= seen_q || tgt_wr;
                if (!period_ok) begin
                    sync_q <= 1'b0;
                end
            end
        end
    end

    assign follow = (is_csp || is_csv) && sync_q && ctl_enable && !ctl_qstop;

    // Position range wrap, then software limits
    always_comb begin
        span    = rng_max - rng_min;
        wrapped = tgt_pos;
        if (rng_max > rng_min) begin
            if (tgt_pos > rng_max) begin
                wrapped = tgt_pos - span - ONE;
            end else if (tgt_pos < rng_min) begin
                wrapped = tgt_pos + span + ONE;
            end
        end
        lim_ex  = (wrapped > swl_max) || (wrapped < swl_min);
        demand  = clamp(wrapped, swl_min, swl_max);
        err     = demand - act_q;
        err_abs = err[DATA_W-1] ? -err : err;
    end

    // Speed command: no ramp toward the target; the maximum speed bounds it and a limit switch zeroes it in its direction
    always_comb begin
        cmd = RST_ZERO;
        if (follow && is_csp) begin
            cmd = clamp(err, -max_spd, max_spd);
        end else if (follow && is_csv) begin
            cmd = clamp(sw_t'(prm_q[SEL_TGT_VEL]), -max_spd, max_spd);
        end
        if ((POS_LIMIT_SW && cmd > 0) || (NEG_LIMIT_SW && cmd < 0)) begin
            cmd = RST_ZERO;
        end
        spd_d = cmd;
        if (ctl_qstop) begin
            if (prm_q[SEL_QS_OPT][7:0] == QS_OPT_COAST) begin
                spd_d = RST_ZERO;
            end else if (spd_q > sw_t'(prm_q[SEL_QS_DEC])) begin
                spd_d = spd_q - sw_t'(prm_q[SEL_QS_DEC]);
            end else if (spd_q < -sw_t'(prm_q[SEL_QS_DEC])) begin
                spd_d = spd_q + sw_t'(prm_q[SEL_QS_DEC]);
            end else begin
                spd_d = RST_ZERO;
            end
        end
    end

    // Motion integrates once per millisecond
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            spd_q <= RST_ZERO;
            act_q <= RST_ZERO;
        end else if (CE && tick) begin
            spd_q <= spd_d;
            act_q <= act_q + spd_d;
        end
    end

    // Out-of-window time counted in millisecond ticks, saturating
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fe_cnt_q <= RST_ZERO;
        end else if (CE) begin
            if (!is_csp || err_abs <= sw_t'(prm_q[SEL_FE_WIN])) begin
                fe_cnt_q <= RST_ZERO;
            end else if (tick && fe_cnt_q != RST_SWL_MAX) begin
                fe_cnt_q <= fe_cnt_q + ONE;
            end
        end
    end

    assign fe_out = is_csp && (fe_cnt_q > prm_q[SEL_FE_TMO]);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            status_q <= '0;
            fe_out_q <= RST_ZERO;
        end else if (CE) begin
            status_q            <= '0;
            status_q[ST_SYNC]   <= sync_q;
            status_q[ST_LIMIT]  <= lim_ex;
            status_q[ST_FOLLOW] <= follow;
            status_q[ST_FERR]   <= fe_out;
            fe_out_q            <= err;
        end
    end

    assign LINK.status  = status_q;
    assign LINK.pos_act = act_q;
    assign LINK.vel_act = spd_q;
    assign LINK.fe_act  = fe_out_q;
    assign MOTOR_SPEED  = spd_q;
    assign ACTUAL_POS   = act_q;
endmodule

// ===== rtl/csf_ctl.sv
// Controller end: APB register file for software, forwards parameters over the
// link and resends the active target once per cycle period.
`timescale 1ns/1ps
module csf_ctl
    import csf_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    csf_link_if.ctl                LINK,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [DATA_W-1:0] PWDATA,
    output logic      [DATA_W-1:0] PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR
);
    logic [DATA_W-1:0] shd_q [NUM_SEL];
    logic              tick;
    logic [DATA_W-1:0] cyc_cnt_q;
    logic              resend_q;
    logic              wr_valid_q;
    sel_e              wr_sel_q;
    logic [DATA_W-1:0] wr_data_q;
    logic [DATA_W-1:0] rdata_q;
    logic              is_prm;
    logic              is_ro;
    logic              apb_wr;
    logic              cyc_end;
    sel_e              widx;
    sel_e              tgt_sel;
    logic              tgt_mode;

    csf_ms_tick #(
        .CYCLES (MS_CYCLES)
    ) u_tick (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .ce    (CE),
        .tick  (tick)
    );

    assign widx     = sel_e'(PADDR[SEL_W+1:2]);
    assign is_prm   = (PADDR[1:0] == 2'h0) && (PADDR < ADDR_W'(NUM_SEL * 4));
    assign is_ro    = (PADDR == ADDR_STATUS) || (PADDR == ADDR_POS)
                      || (PADDR == ADDR_VEL) || (PADDR == ADDR_FE);
    assign PREADY   = 1'b1;
    assign PSLVERR  = PSEL && PENABLE && !(is_prm || (is_ro && !PWRITE));
    assign apb_wr   = CE && PSEL && PENABLE && PWRITE && is_prm;
    assign PRDATA   = rdata_q;
    assign tgt_mode = (shd_q[SEL_MODE][7:0] == MODE_CSP)
                      || (shd_q[SEL_MODE][7:0] == MODE_CSV);
    assign tgt_sel  = (shd_q[SEL_MODE][7:0] == MODE_CSP) ? SEL_TGT_POS : SEL_TGT_VEL;
    assign cyc_end  = tick && (cyc_cnt_q + ONE >= shd_q[SEL_IP_PER]);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < NUM_SEL; i++) begin
                shd_q[i] <= RST_ZERO;
            end
            shd_q[SEL_SWL_MIN] <= RST_SWL_MIN;
            shd_q[SEL_SWL_MAX] <= RST_SWL_MAX;
            shd_q[SEL_IP_PER]  <= RST_IP_PER;
            shd_q[SEL_IP_IDX]  <= RST_IP_IDX;
            shd_q[SEL_MAX_SPD] <= RST_MAX_SPD;
        end else if (apb_wr) begin
            shd_q[widx] <= PWDATA;
        end
    end

    // Read data is fetched during the setup cycle
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= RST_ZERO;
        end else if (CE && PSEL && !PENABLE) begin
            if (is_prm) begin
                rdata_q <= shd_q[widx];
            end else if (PADDR == ADDR_STATUS) begin
                rdata_q <= DATA_W'(LINK.status);
            end else if (PADDR == ADDR_POS) begin
                rdata_q <= LINK.pos_act;
            end else if (PADDR == ADDR_VEL) begin
                rdata_q <= LINK.vel_act;
            end else if (PADDR == ADDR_FE) begin
                rdata_q <= LINK.fe_act;
            end else begin
                rdata_q <= RST_ZERO;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cyc_cnt_q <= RST_ZERO;
        end else if (CE && tick) begin
            cyc_cnt_q <= cyc_end ? RST_ZERO : cyc_cnt_q + ONE;
        end
    end

    // Software writes go first; a periodic resend waits a cycle if they collide
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_valid_q <= 1'b0;
            wr_sel_q   <= SEL_MODE;
            wr_data_q  <= RST_ZERO;
            resend_q   <= 1'b0;
        end else if (CE) begin
            wr_valid_q <= 1'b0;
            if (apb_wr) begin
                wr_valid_q <= 1'b1;
                wr_sel_q   <= widx;
                wr_data_q  <= PWDATA;
                resend_q   <= resend_q || (cyc_end && tgt_mode);
            end else if (resend_q || (cyc_end && tgt_mode)) begin
                wr_valid_q <= 1'b1;
                wr_sel_q   <= tgt_sel;
                wr_data_q  <= shd_q[tgt_sel];
                resend_q   <= 1'b0;
            end
        end
    end

    assign LINK.wr_valid = wr_valid_q;
    assign LINK.wr_sel   = wr_sel_q;
    assign LINK.wr_data  = wr_data_q;
endmodule

// ===== dv/csf_link_sva.sv
// Checker for the link between the controller end and the drive end.
// Assumes it sees the link signals and the shared clock, reset and clock enable.
`timescale 1ns/1ps
module csf_link_sva
    import csf_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic              CORE_CLK,
    input wire logic              RST_N,
    input wire logic              ce,
    input wire logic              wr_valid,
    input wire sel_e              wr_sel,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [STAT_W-1:0] status,
    input wire logic [DATA_W-1:0] vel_act
);
    logic [7:0]        mode_q;
    logic [DATA_W-1:0] per_q;
    logic [DATA_W-1:0] max_q;
    int                since_q;
    int                age_q;
    logic              cfg;
    logic              tgt;
    int                lim;

    assign cfg = wr_valid && (wr_sel == SEL_MODE || wr_sel == SEL_MAX_SPD);
    assign tgt = wr_valid && wr_sel == ((mode_q == MODE_CSV) ? SEL_TGT_VEL : SEL_TGT_POS);
    assign lim = int'(per_q) * MS_CYCLES + 4;

    // Shadow of the settings that the properties depend on
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q <= 8'h00;
            per_q  <= RST_IP_PER;
            max_q  <= RST_MAX_SPD;
        end else if (wr_valid) begin
            if (wr_sel == SEL_MODE) mode_q <= wr_data[7:0];
            if (wr_sel == SEL_IP_PER) per_q <= wr_data;
            if (wr_sel == SEL_MAX_SPD) max_q <= wr_data;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            since_q <= 0;
            age_q   <= 0;
        end else if (ce) begin
            since_q <= (tgt || cfg) ? 0 : since_q + 1;
            age_q   <= cfg ? 0 : age_q + 1;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    property p_resv; (status & 16'hc6ff) == 16'h0000; endproperty
    a_resv: assert property (p_resv) else $error("reserved status bit set");
    property p_sync; status[ST_FOLLOW] |-> status[ST_SYNC]; endproperty
    a_sync: assert property (p_sync) else $error("following without sync");
    property p_idx;
        wr_valid && wr_sel == SEL_IP_IDX && wr_data[7:0] != TIME_IDX_MS |-> ##[1:3] !status[ST_SYNC];
    endproperty
    a_idx: assert property (p_idx) else $error("sync kept with bad index");
    property p_start;
        $past(vel_act) == 32'h0 && vel_act != 32'h0 |-> ##[0:2] status[ST_FOLLOW];
    endproperty
    a_start: assert property (p_start) else $error("motion without following");
    property p_mode;
        status[ST_FOLLOW] && age_q > 16 |-> mode_q == MODE_CSP || mode_q == MODE_CSV;
    endproperty
    a_mode: assert property (p_mode) else $error("following in wrong mode");
    property p_max;
        age_q > MS_CYCLES + 4 |-> $signed(vel_act) <= $signed(max_q)
            && $signed(vel_act) >= -$signed(max_q);
    endproperty
    a_max: assert property (p_max) else $error("speed above maximum");
    property p_resend; status[ST_FOLLOW] |-> since_q <= lim; endproperty
    a_resend: assert property (p_resend) else $error("target not resent");
    property p_rise; $rose(status[ST_SYNC]) |-> since_q <= lim; endproperty
    a_rise: assert property (p_rise) else $error("sync without target");
endmodule

// ===== dv/cyclic_sync_setpoint_follower_tb.sv
// Testbench joining controller and drive over the link, driven over APB.
// Assumes the short millisecond count below for both ends.
`timescale 1ns/1ps
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (x)); end end
module cyclic_sync_setpoint_follower_tb;
    import csf_pkg::*;
    localparam int MS = 10;
    logic              clk;
    logic              rst_n;
    logic              ce;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              pos_sw;
    logic              neg_sw;
    logic [DATA_W-1:0] speed;
    logic [DATA_W-1:0] pos;
    logic [DATA_W-1:0] q;
    logic              e;
    int                num_errors;
    int                tests_run;

    csf_link_if csf_link_if_i ();
    csf_ctl #(.MS_CYCLES(MS)) csf_ctl_i (.CORE_CLK(clk), .RST_N(rst_n), .CE(ce),
        .LINK(csf_link_if_i), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    csf_drive #(.MS_CYCLES(MS)) csf_drive_i (.CORE_CLK(clk), .RST_N(rst_n), .CE(ce),
        .LINK(csf_link_if_i), .POS_LIMIT_SW(pos_sw), .NEG_LIMIT_SW(neg_sw),
        .MOTOR_SPEED(speed), .ACTUAL_POS(pos));
    csf_link_sva #(.MS_CYCLES(MS)) csf_link_sva_i (.CORE_CLK(clk), .RST_N(rst_n), .ce(ce),
        .wr_valid(csf_link_if_i.wr_valid), .wr_sel(csf_link_if_i.wr_sel),
        .wr_data(csf_link_if_i.wr_data), .status(csf_link_if_i.status),
        .vel_act(csf_link_if_i.vel_act));

    always #5 clk = ~clk;

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One APB transfer with an idle cycle before its setup
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        `CHK(e, 1'b0)
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask

    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        while (csf_link_if_i.status[b] !== v && n < 500) begin
            @(posedge clk);
            n++;
        end
        `CHK(csf_link_if_i.status[b], v)
    endtask

    // Waits for speed (s high) or position to reach a value
    task automatic wait_val(input logic s, input logic [31:0] v);
        int n;
        n = 0;
        while ((s ? speed : pos) !== v && n < 2000) begin
            @(posedge clk);
            n++;
        end
        `CHK((s ? speed : pos), v)
    endtask

    task automatic t_regs;
        rd(8'h0c, RST_SWL_MIN);
        rd(8'h10, RST_SWL_MAX);
        rd(8'h2c, RST_MAX_SPD);
        rd(8'h30, RST_IP_PER);
        rd(8'h34, RST_IP_IDX);
        rd(8'h40, RST_ZERO);
        apb(1'b0, 8'h50, 32'h0);
        `CHK({e, q}, {1'b1, RST_ZERO})
        apb(1'b1, 8'h40, ONE);
        `CHK(e, 1'b1)
        $display("register test done");
    endtask

    task automatic t_csp;
        wr(8'h00, 32'h8);
        wr(8'h04, 32'h30);
        wr(8'h04, 32'h30);
        wr(8'h38, ONE);
        wait_bit(ST_SYNC, 1'b1);
        wait_bit(ST_FOLLOW, 1'b1);
        wait_val(1'b1, 32'h30);
        wait_val(1'b0, 32'h30);
        repeat (2 * MS) @(posedge clk);
        rd(8'h40, 32'h1100);
        rd(8'h44, 32'h30);
        rd(8'h48, RST_ZERO);
        rd(8'h4c, RST_ZERO);
        wr(8'h18, 32'hff);
        wr(8'h04, 32'h105);
        wait_val(1'b0, 32'h5);
        wr(8'h10, 32'h40);
        wr(8'h04, 32'h80);
        wait_bit(ST_LIMIT, 1'b1);
        wait_val(1'b0, 32'h40);
        wr(8'h04, 32'h20);
        wr(8'h18, RST_ZERO);
        wait_bit(ST_LIMIT, 1'b0);
        wait_val(1'b0, 32'h20);
        wr(8'h10, RST_SWL_MAX);
        $display("position test done");
    endtask

    task automatic t_fe;
        wr(8'h2c, 32'h10);
        wr(8'h20, 32'h3);
        wr(8'h04, 32'h420);
        wait_val(1'b1, 32'h10);
        // Clock enable low must freeze motion and the error timer alike
        ce <= 1'b0;
        @(posedge clk);
        q = pos;
        repeat (2 * MS) @(posedge clk);
        `CHK(pos, q)
        ce <= 1'b1;
        repeat (2 * MS + 5) @(posedge clk);
        `CHK(csf_link_if_i.status[ST_FERR], 1'b0)
        repeat (2 * MS) @(posedge clk);
        `CHK(csf_link_if_i.status[ST_FERR], 1'b1)
        wr(8'h1c, 32'h1000);
        wait_bit(ST_FERR, 1'b0);
        $display("following error test done");
    endtask

    task automatic t_qs;
        wr(8'h24, 32'h4);
        wr(8'h28, ONE);
        wr(8'h38, 32'h3);
        wait_val(1'b1, 32'hc);
        wait_val(1'b1, 32'h8);
        wait_val(1'b1, 32'h0);
        `CHK(csf_link_if_i.status[ST_FOLLOW], 1'b0)
        wr(8'h38, ONE);
        wait_val(1'b1, 32'h10);
        wr(8'h28, RST_ZERO);
        wr(8'h38, 32'h3);
        repeat (MS + 2) @(posedge clk);
        `CHK(speed, 32'h0)
        $display("quick stop test done");
    endtask

    task automatic t_csv;
        wr(8'h08, 32'h8);
        wr(8'h00, 32'h9);
        wr(8'h38, ONE);
        wait_val(1'b1, 32'h8);
        wait_bit(ST_FOLLOW, 1'b1);
        pos_sw <= 1'b1;
        wait_val(1'b1, 32'h0);
        pos_sw <= 1'b0;
        neg_sw <= 1'b1;
        wait_val(1'b1, 32'h8);
        wr(8'h08, 32'hffff_fff8);
        wait_val(1'b1, 32'h0);
        neg_sw <= 1'b0;
        wait_val(1'b1, 32'hffff_fff8);
        wr(8'h34, 32'hffff_fffe);
        wait_bit(ST_SYNC, 1'b0);
        wait_bit(ST_FOLLOW, 1'b0);
        wr(8'h34, RST_IP_IDX);
        wait_bit(ST_SYNC, 1'b1);
        wr(8'h30, 32'h2);
        repeat (6 * MS) @(posedge clk);
        `CHK(csf_link_if_i.status[ST_SYNC], 1'b1)
        $display("velocity test done");
    endtask

    initial begin
        clk        = 1'b0;
        rst_n      = 1'b0;
        ce         = 1'b1;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = '0;
        pwdata     = '0;
        pos_sw     = 1'b0;
        neg_sw     = 1'b0;
        num_errors = 0;
        tests_run  = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_csp;
        t_fe;
        t_qs;
        t_csv;
        end_of_test;
    end

    // Cuts a hang short well after the few hundred cycles the tests need
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        $display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
        end_of_test;
    end
endmodule
